//--- hdl/irq_port_pkg.sv
package irq_port_pkg;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_MSI_CTRL   = 8'h00;
	localparam logic [7:0] REG_MSI_DATA   = 8'h04;
	localparam logic [7:0] REG_MSIX_CTRL  = 8'h08;
	localparam logic [7:0] REG_CFG        = 8'h0c;
	localparam logic [7:0] REG_STATE      = 8'h10;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
	localparam logic [7:0] REG_IRQ_MASK   = 8'h18;
	localparam logic [7:0] REG_MSG_LOG    = 8'h1c;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int MSI_ON_BIT      = 0;
	localparam int MMEN_LSB        = 4;
	localparam int MSIX_ON_BIT     = 0;
	localparam int MSIX_FMASK_BIT  = 1;
	localparam int STAT_AUTO_BIT   = 0;
	localparam int INT_STATUS_BIT  = 3;
	localparam int EV_MSG_SENT     = 0;
	localparam int EV_LEGACY_CHG   = 1;
	localparam int EV_COUNT        = 2;

	// ---------------------------------------------------------------
	// reset values and encodings
	// ---------------------------------------------------------------
	localparam logic [2:0] MMEN_MAX     = 3'h5;
	localparam logic [2:0] MMEN_RESET   = 3'h0;
	localparam logic [7:0] MSI_DATA_RST = 8'h00;
	localparam logic [7:0] INTX_A       = 8'h00;
	localparam logic [7:0] INTX_C       = 8'h02;
	localparam int         INTX_LINES   = 3;
	localparam logic [1:0] AXI_OKAY     = 2'h0;
	localparam logic [1:0] AXI_SLVERR   = 2'h2;

	// message kinds in the log register
	localparam logic [1:0] MSG_ASSERT   = 2'h0;
	localparam logic [1:0] MSG_DEASSERT = 2'h1;
	localparam logic [1:0] MSG_MSI      = 2'h2;

	// ---------------------------------------------------------------
	// timing: cycles the message takes to leave
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEND_TIME_NS  = 40;
	localparam int SEND_CYCLES   = (SEND_TIME_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

endpackage

//--- hdl/irq_request_port.sv
// Notes on behaviour
// - For legacy requests a low select sends Assert, high Deassert; MSI ignores it.
// - With single-vector MSI the vector input plays no part in the message.
// - The MSI data output shows the low eight bits of the Message Data field.
// - The three-bit Multiple Message Enable field is output, from 000b to 101b.
// - The MSI enabled output is low for legacy only and high with MSI enabled.
// - The MSI-X enabled output is high while MSI-X is enabled.
// - A dedicated output mirrors the MSI-X Function Mask bit.
// - An asserted request sends a message of the type chosen by select and the MSI enable; a legacy one with a vector above INTX_C sends none.
// - Grant low together with request low means the message went out.
// - With automatic status off, Status bit 3 follows the status input.
`timescale 1ns/1ps

module irq_request_port
	import irq_port_pkg::*;
#(
	parameter int SEND_CYCLES_P = SEND_CYCLES
)(
	input  wire logic        CORE_CLK,
	input  wire logic        RSTN,
	input  wire logic        IRQ_REQUEST_N,
	input  wire logic        LEGACY_ASSERT_SELECT,
	input  wire logic [7:0]  IRQ_VECTOR_IN,
	input  wire logic        IRQ_STATUS_IN_N,
	output logic             IRQ_GRANT_N,
	output logic [7:0]       MSI_DATA_LOW_OUT,
	output logic [2:0]       MSI_MULTI_MSG_ENABLE,
	output logic             MSI_ON,
	output logic             MSIX_ON,
	output logic             MSIX_FUNCTION_MASK,
	output logic             INT_STATUS_BIT_OUT,
	output logic             IRQ,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY
);

	// counter is eight bits wide
	if (SEND_CYCLES_P < 1 || SEND_CYCLES_P > 255)
	begin : g_bad_send_cycles
		$error("SEND_CYCLES_P out of range");
	end

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SEND  = 2'b01,
		ST_GRANT = 2'b10,
		ST_DROP  = 2'b11
	} send_e;

	// ---------------------------------------------------------------
	// input synchronisers for the status pin
	// ---------------------------------------------------------------
	logic stat_meta_q;
	logic stat_sync_q;

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			stat_meta_q <= 1'b1;
			stat_sync_q <= 1'b1;
		end
		else
		begin
			stat_meta_q <= IRQ_STATUS_IN_N;
			stat_sync_q <= stat_meta_q;
		end
	end

	// ---------------------------------------------------------------
	// configuration state
	// ---------------------------------------------------------------
	logic       msi_on_q;
	logic [2:0] mmen_q;
	logic [7:0] msi_data_q;
	logic       msix_on_q;
	logic       msix_fmask_q;
	logic       stat_auto_q;
	logic [EV_COUNT-1:0] irq_status_q;
	logic [EV_COUNT-1:0] irq_mask_q;
	logic [INTX_LINES-1:0] intx_pending_q;
	logic [9:0] msg_log_q;

	// ---------------------------------------------------------------
	// request sampling and message formation
	// ---------------------------------------------------------------
	send_e      state_q;
	logic [7:0] cnt_q;
	logic       sel_q;
	logic [7:0] vec_q;

	// vector mask of 2^mmen values; single vector gives zero
	wire [7:0] vec_mask = 8'((9'h001 << mmen_q) - 9'h001);
	wire [7:0] msi_vec  = (msi_data_q & ~vec_mask)
		| (IRQ_VECTOR_IN & vec_mask);
	wire legacy_ok = (IRQ_VECTOR_IN <= INTX_C);
	wire req_take  = (state_q == ST_IDLE) && !IRQ_REQUEST_N
		&& (msi_on_q || legacy_ok);
	wire send_done = (state_q == ST_SEND)
		&& (cnt_q == 8'(SEND_CYCLES_P - 1));
	wire [1:0] msg_kind = msi_on_q ? MSG_MSI
		: (LEGACY_ASSERT_SELECT ? MSG_DEASSERT : MSG_ASSERT);
	wire [7:0] msg_vec = msi_on_q ? msi_vec : IRQ_VECTOR_IN;
	wire [1:0] intx_idx = vec_q[1:0];

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			state_q <= ST_IDLE;
			cnt_q   <= 8'h00;
			sel_q   <= 1'b0;
			vec_q   <= 8'h00;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					cnt_q <= 8'h00;
					if (req_take)
					begin
						state_q <= ST_SEND;
						sel_q   <= LEGACY_ASSERT_SELECT;
						vec_q   <= msg_vec;
					end
				end
				ST_SEND:
				begin
					cnt_q <= cnt_q + 8'h01;
					if (send_done)
						state_q <= ST_GRANT;
				end
				ST_GRANT:
					state_q <= ST_DROP;
				ST_DROP:
					if (IRQ_REQUEST_N)
						state_q <= ST_IDLE;
			endcase
		end
	end

	// grant is a single cycle low after the last send cycle, whether or not the request is still held
	wire grant_d = !(send_done);
	wire msg_sent = (state_q == ST_GRANT);

	// ---------------------------------------------------------------
	// legacy pending state and interrupt status bit
	// ---------------------------------------------------------------
	logic [INTX_LINES-1:0] intx_pending_d;

	always_comb
	begin
		intx_pending_d = intx_pending_q;
		if (msg_sent && msg_log_q[9:8] != MSG_MSI)
			intx_pending_d[intx_idx] = (msg_log_q[9:8] == MSG_ASSERT);
	end

	wire int_status_d = stat_auto_q ? (|intx_pending_q)
		: !stat_sync_q;

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	logic       aw_held_q;
	logic       w_held_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;

	wire aw_now   = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_now    = S_AXI_WVALID && S_AXI_WREADY;
	wire aw_have  = aw_held_q || aw_now;
	wire w_have   = w_held_q || w_now;
	wire wr_fire  = aw_have && w_have && !S_AXI_BVALID;
	wire [7:0]  wa   = aw_held_q ? awaddr_q : S_AXI_AWADDR;
	wire [31:0] wd   = w_held_q ? wdata_q : S_AXI_WDATA;
	wire [3:0]  ws   = w_held_q ? wstrb_q : S_AXI_WSTRB;
	wire wr_lane0 = wr_fire && ws[0];
	wire wr_ok    = (wa <= REG_MSG_LOG) && (wa[1:0] == 2'b00);
	wire rd_fire  = S_AXI_ARVALID && S_AXI_ARREADY;
	wire rd_ok    = (S_AXI_ARADDR <= REG_MSG_LOG)
		&& (S_AXI_ARADDR[1:0] == 2'b00);
	wire rd_status = rd_fire && (S_AXI_ARADDR == REG_IRQ_STATUS);
	wire [EV_COUNT-1:0] events = {intx_pending_d != intx_pending_q,
		msg_sent};
	wire [2:0] mmen_wr = (wd[MMEN_LSB +: 3] > MMEN_MAX) ? MMEN_MAX
		: wd[MMEN_LSB +: 3];

	logic [31:0] rd_mux;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		unique case (S_AXI_ARADDR)
			REG_MSI_CTRL:   rd_mux = {25'h0, mmen_q, 3'h0, msi_on_q};
			REG_MSI_DATA:   rd_mux = {24'h0, msi_data_q};
			REG_MSIX_CTRL:  rd_mux = {30'h0, msix_fmask_q, msix_on_q};
			REG_CFG:        rd_mux = {31'h0, stat_auto_q};
			REG_STATE:      rd_mux = {25'h0, intx_pending_q,
				INT_STATUS_BIT_OUT, 1'b0, state_q};
			REG_IRQ_STATUS: rd_mux = {30'h0, irq_status_q};
			REG_IRQ_MASK:   rd_mux = {30'h0, irq_mask_q};
			REG_MSG_LOG:    rd_mux = {22'h0, msg_log_q};
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY  <= 1'b0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= AXI_OKAY;
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= AXI_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_have && !S_AXI_BVALID;
			S_AXI_WREADY  <= !w_have && !S_AXI_BVALID;
			if (aw_now)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= S_AXI_AWADDR;
			end
			if (w_now)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= S_AXI_WDATA;
				wstrb_q  <= S_AXI_WSTRB;
			end
			if (wr_fire)
			begin
				aw_held_q     <= 1'b0;
				w_held_q      <= 1'b0;
				S_AXI_AWREADY <= 1'b0;
				S_AXI_WREADY  <= 1'b0;
				S_AXI_BVALID  <= 1'b1;
				S_AXI_BRESP   <= wr_ok ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
			S_AXI_ARREADY <= !S_AXI_ARVALID || S_AXI_ARREADY ? 1'b0
				: !S_AXI_RVALID;
			if (rd_fire)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_mux;
				S_AXI_RRESP  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
			end
			else if (S_AXI_RVALID && S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// configuration registers and outputs
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			msi_on_q       <= 1'b0;
			mmen_q         <= MMEN_RESET;
			msi_data_q     <= MSI_DATA_RST;
			msix_on_q      <= 1'b0;
			msix_fmask_q   <= 1'b0;
			stat_auto_q    <= 1'b0;
			irq_mask_q     <= '0;
			irq_status_q   <= '0;
			intx_pending_q <= '0;
			msg_log_q      <= 10'h000;
		end
		else
		begin
			if (wr_lane0 && wa == REG_MSI_CTRL)
			begin
				msi_on_q <= wd[MSI_ON_BIT];
				mmen_q   <= mmen_wr;
			end
			if (wr_lane0 && wa == REG_MSI_DATA)
				msi_data_q <= wd[7:0];
			if (wr_lane0 && wa == REG_MSIX_CTRL)
			begin
				msix_on_q    <= wd[MSIX_ON_BIT];
				msix_fmask_q <= wd[MSIX_FMASK_BIT];
			end
			if (wr_lane0 && wa == REG_CFG)
				stat_auto_q <= wd[STAT_AUTO_BIT];
			if (wr_lane0 && wa == REG_IRQ_MASK)
				irq_mask_q <= wd[EV_COUNT-1:0];
			// set wins over the read clear
			irq_status_q <= (rd_status ? '0 : irq_status_q) | events;
			intx_pending_q <= intx_pending_d;
			if (req_take)
				msg_log_q <= {msg_kind, msg_vec};
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			IRQ_GRANT_N          <= 1'b1;
			MSI_DATA_LOW_OUT     <= MSI_DATA_RST;
			MSI_MULTI_MSG_ENABLE <= MMEN_RESET;
			MSI_ON               <= 1'b0;
			MSIX_ON              <= 1'b0;
			MSIX_FUNCTION_MASK   <= 1'b0;
			INT_STATUS_BIT_OUT   <= 1'b0;
			IRQ                  <= 1'b0;
		end
		else
		begin
			IRQ_GRANT_N          <= grant_d;
			MSI_DATA_LOW_OUT     <= msi_data_q;
			MSI_MULTI_MSG_ENABLE <= mmen_q;
			MSI_ON               <= msi_on_q;
			MSIX_ON              <= msix_on_q;
			MSIX_FUNCTION_MASK   <= msix_fmask_q;
			INT_STATUS_BIT_OUT   <= int_status_d;
			IRQ                  <= |(irq_status_q & irq_mask_q);
		end
	end

endmodule // irq_request_port

//--- verification/irq_port_chk.sv
`timescale 1ns/1ps

module irq_port_chk
	import irq_port_pkg::*;
(
	input wire logic       CORE_CLK,
	input wire logic       RSTN,
	input wire logic       IRQ_REQUEST_N,
	input wire logic [7:0] IRQ_VECTOR_IN,
	input wire logic       IRQ_GRANT_N,
	input wire logic [7:0] MSI_DATA_LOW_OUT,
	input wire logic [2:0] MSI_MULTI_MSG_ENABLE,
	input wire logic       MSI_ON,
	input wire logic       MSIX_ON,
	input wire logic       MSIX_FUNCTION_MASK,
	input wire logic       S_AXI_BVALID
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	AST_GRANT_ONE_CYCLE: assert property (!IRQ_GRANT_N |=> IRQ_GRANT_N)
		else $error("grant low longer than one cycle");
	AST_GRANT_WITH_REQ: assert property (!IRQ_GRANT_N |-> !IRQ_REQUEST_N)
		else $error("grant without a request");
	AST_REQ_ANSWERED: assert property ($fell(IRQ_REQUEST_N) &&
		(MSI_ON || IRQ_VECTOR_IN <= INTX_C) |-> ##[1:8] !IRQ_GRANT_N)
		else $error("request not granted in time");
	AST_MMEN_RANGE: assert property (MSI_MULTI_MSG_ENABLE <= MMEN_MAX)
		else $error("multi message enable above five");
	AST_MSI_ON_WRITE: assert property ($changed(MSI_ON)
		|-> $past(S_AXI_BVALID))
		else $error("msi enable changed without a write");
	AST_MSIX_ON_WRITE: assert property ($changed(MSIX_ON)
		|-> $past(S_AXI_BVALID))
		else $error("msix enable changed without a write");
	AST_FMASK_WRITE: assert property ($changed(MSIX_FUNCTION_MASK)
		|-> $past(S_AXI_BVALID))
		else $error("function mask changed without a write");
	AST_DATA_WRITE: assert property ($changed(MSI_DATA_LOW_OUT)
		|-> $past(S_AXI_BVALID))
		else $error("msi data changed without a write");
endmodule // irq_port_chk

bind irq_request_port irq_port_chk i_chk (
	.CORE_CLK(CORE_CLK), .RSTN(RSTN), .IRQ_REQUEST_N(IRQ_REQUEST_N),
	.IRQ_VECTOR_IN(IRQ_VECTOR_IN), .IRQ_GRANT_N(IRQ_GRANT_N),
	.MSI_DATA_LOW_OUT(MSI_DATA_LOW_OUT), .MSI_ON(MSI_ON),
	.MSI_MULTI_MSG_ENABLE(MSI_MULTI_MSG_ENABLE), .MSIX_ON(MSIX_ON),
	.MSIX_FUNCTION_MASK(MSIX_FUNCTION_MASK), .S_AXI_BVALID(S_AXI_BVALID)
);

//--- verification/irq_app_model.sv
`timescale 1ns/1ps

module irq_app_model
(
	input  wire logic       clk,
	input  wire logic       grant_n,
	output logic            req_n,
	output logic            sel,
	output logic [7:0]      vec
);
	initial
	begin
		req_n = 1'b1;
		sel   = 1'b0;
		vec   = 8'h00;
	end

	// raise request after a delay, hold all until grant or for at most 40 cycles
	task automatic send(input logic s, input logic [7:0] v,
		input int dly, output logic ok);
		int n;
		ok = 1'b0;
		repeat (dly) @(posedge clk);
		req_n <= 1'b0;
		sel   <= s;
		vec   <= v;
		for (n = 0; n < 40 && !ok; n++)
		begin
			@(posedge clk);
			ok = !grant_n;
		end
		req_n <= 1'b1;
		sel   <= ~s;
		vec   <= ~v;
	endtask
endmodule // irq_app_model

//--- verification/irq_request_port_tb.sv
`timescale 1ns/1ps

module irq_request_port_tb
	import irq_port_pkg::*;
;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        stat_n = 1'b1;
	logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0;
	logic        r_r = 1'b0;
	logic [7:0]  aw_a = 8'h00;
	logic [31:0] w_d = 32'h0;
	logic        req_n, sel, gnt_n, msi_on, msix_on, fmask, st_bit, irq;
	logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [7:0]  vec, dout;
	logic [2:0]  mmen;
	logic [1:0]  b_resp, r_resp;
	logic [31:0] r_d, q;
	logic        ok;
	int          n_errors = 0;
	int          checked = 0;

	always #5 clk = ~clk;

	irq_request_port i_dut (
		.CORE_CLK(clk), .RSTN(rstn), .IRQ_REQUEST_N(req_n),
		.LEGACY_ASSERT_SELECT(sel), .IRQ_VECTOR_IN(vec), .IRQ(irq),
		.IRQ_STATUS_IN_N(stat_n), .IRQ_GRANT_N(gnt_n), .MSI_ON(msi_on),
		.MSI_DATA_LOW_OUT(dout), .MSI_MULTI_MSG_ENABLE(mmen),
		.MSIX_ON(msix_on), .MSIX_FUNCTION_MASK(fmask),
		.INT_STATUS_BIT_OUT(st_bit), .S_AXI_AWADDR(aw_a),
		.S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d),
		.S_AXI_WSTRB(4'hf), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_rdy),
		.S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
		.S_AXI_ARADDR(aw_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy),
		.S_AXI_RDATA(r_d), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_v),
		.S_AXI_RREADY(r_r)
	);

	irq_app_model i_app (
		.clk(clk), .grant_n(gnt_n), .req_n(req_n), .sel(sel), .vec(vec)
	);

	task automatic chk(input string nm, input logic [31:0] e, g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one write (w=1) or read (w=0), waits for the answer
	task automatic axi(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge clk);
		aw_a <= a;
		w_d  <= d;
		aw_v <= w;
		w_v  <= w;
		b_r  <= w;
		ar_v <= !w;
		r_r  <= !w;
		while (!got)
		begin
			@(posedge clk);
			if (aw_rdy)
				aw_v <= 1'b0;
			if (w_rdy)
				w_v <= 1'b0;
			if (ar_rdy)
				ar_v <= 1'b0;
			if (b_v || r_v)
			begin
				got = 1'b1;
				q = r_d;
				b_r <= 1'b0;
				r_r <= 1'b0;
				chk("resp", er, w ? b_resp : r_resp);
			end
		end
		// let the registered outputs settle before callers look
		@(posedge clk);
		chk("valid drop", 1'b0, b_v || r_v);
	endtask

	task automatic t_cfg();
		axi(0, REG_MSI_CTRL, 0, AXI_OKAY);
		chk("msi_ctrl reset", 32'h0, q);
		axi(1, REG_MSI_CTRL, 32'h71, AXI_OKAY);
		chk("mmen clamp", MMEN_MAX, mmen);
		chk("msi on", 1'b1, msi_on);
		axi(1, REG_MSI_DATA, 32'h5a, AXI_OKAY);
		chk("msi data", 8'h5a, dout);
		axi(1, REG_MSIX_CTRL, 32'h2, AXI_OKAY);
		chk("msix", 2'h2, {fmask, msix_on});
		axi(1, REG_MSIX_CTRL, 32'h1, AXI_OKAY);
		chk("msix", 2'h1, {fmask, msix_on});
		axi(0, 8'h20, 0, AXI_SLVERR);
		axi(1, 8'h20, 0, AXI_SLVERR);
		axi(1, REG_MSI_CTRL, 0, AXI_OKAY);
		chk("msi off", 1'b0, msi_on);
		$display("test cfg done");
	endtask

	task automatic t_legacy();
		for (int i = 0; i < 2 * INTX_LINES; i++)
		begin
			i_app.send(i >= INTX_LINES, 8'(i % INTX_LINES), 2 + i, ok);
			chk("legacy grant", 1'b1, ok);
			axi(0, REG_MSG_LOG, 0, AXI_OKAY);
			chk("legacy log", {i >= INTX_LINES ? MSG_DEASSERT : MSG_ASSERT,
				8'(i % INTX_LINES)}, q);
		end
		i_app.send(1'b0, 8'h03, 2, ok);
		chk("bad line", 1'b0, ok);
		$display("test legacy done");
	endtask

	task automatic t_msi();
		axi(1, REG_MSI_DATA, 32'ha0, AXI_OKAY);
		axi(1, REG_MSI_CTRL, 32'h21, AXI_OKAY);
		axi(1, REG_IRQ_MASK, 32'h1, AXI_OKAY);
		axi(0, REG_IRQ_STATUS, 0, AXI_OKAY);
		i_app.send(1'b1, 8'hff, 2, ok);
		chk("msi grant", 1'b1, ok);
		repeat (2) @(posedge clk);
		chk("irq", 1'b1, irq);
		axi(0, REG_MSG_LOG, 0, AXI_OKAY);
		chk("msi log", {MSG_MSI, 8'ha3}, q);
		axi(0, REG_IRQ_STATUS, 0, AXI_OKAY);
		chk("status", 1'b1, q[0]);
		@(posedge clk);
		chk("irq clear", 1'b0, irq);
		axi(1, REG_MSI_CTRL, 32'h01, AXI_OKAY);
		axi(1, REG_IRQ_MASK, 32'h0, AXI_OKAY);
		i_app.send(1'b0, 8'h5f, 6, ok);
		chk("msi single grant", 1'b1, ok);
		repeat (2) @(posedge clk);
		chk("irq masked", 1'b0, irq);
		axi(0, REG_MSG_LOG, 0, AXI_OKAY);
		chk("msi single", {MSG_MSI, 8'ha0}, q);
		axi(0, REG_IRQ_STATUS, 0, AXI_OKAY);
		chk("status masked", 1'b1, q[0]);
		$display("test msi done");
	endtask

	task automatic t_status();
		axi(1, REG_MSI_CTRL, 0, AXI_OKAY);
		axi(1, REG_CFG, 0, AXI_OKAY);
		stat_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("stat set", 1'b1, st_bit);
		stat_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("stat clear", 1'b0, st_bit);
		axi(1, REG_CFG, 1, AXI_OKAY);
		stat_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("auto ignores pin", 1'b0, st_bit);
		i_app.send(1'b0, 8'h01, 2, ok);
		chk("auto grant", 1'b1, ok);
		repeat (2) @(posedge clk);
		chk("auto pending", 1'b1, st_bit);
		$display("test status done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		t_cfg();
		t_legacy();
		t_msi();
		t_status();
		complete_run();
	end

	initial
	begin
		#100us;
		n_errors++;
		$display("watchdog expired");
		complete_run();
	end
endmodule // irq_request_port_tb
